// ==== verilog/rhc_host_ctrl.sv ====
// Purpose: host-side control and flow-control pins of a hopping radio module
// Assumes: pins are asynchronous to clk; receive-buffer fill is given by the
//   register port; reset pin has an internal pull-up when unconnected
// Notes: serial framing itself is done elsewhere; this block steers it
//   the sleep refusal flag clears when the status word is read
//
// Function
// R01: baud-lock low at boot forces 9600 8-N-1
// R02: baud-lock low wakes from sleep
// R03: internal power-on reset when reset pin floats
// R04: low pulse on reset pin resets fully
// R05: command select low means commands, high payload
// R06: client sync output low only when synchronised
// R07: server holds sync output low always
// R08: RTS gating blocks serial output unless low
// R09: CTS high once fill reaches upper threshold
// R10: CTS low again when fill below lower
// R11: forced mode ignores RTS, 3 ms, receiver off
// R12: forced mode left only through reset
// R13: sleep refused when baud-lock already low
// R14: command mode blocks RF transmit, keeps receive
// R15: upper and lower thresholds give hysteresis
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
module rhc_host_ctrl
  import rhc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic baud_lock_n_pin,
  input wire logic host_reset_n_pin,
  input wire logic cmd_sel_pin,
  input wire logic rts_n_pin,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  output logic cts,
  output logic sync_n,
  output logic ser_tx_allow,
  output logic cmd_mode,
  output logic rf_tx_allow,
  output logic rf_rx_enable,
  output logic [31:0] baud_rate,
  output logic [31:0] if_timeout,
  output logic [7:0] pkt_size,
  output logic core_reset
);

  typedef enum logic [1:0] {RHC_POR, RHC_RUN, RHC_SLEEP} rhc_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // shared decode helpers
  // true when a port strobe targets the given register offset
  function automatic logic reg_hit(input logic stb, input logic [7:0] a, input logic [7:0] off);
    return stb && (a == off);
  endfunction : reg_hit

  // true while the sequencer holds the block in power-on reset
  function automatic logic in_por(input rhc_state_t s);
    return s == RHC_POR;
  endfunction : in_por

  // widens a nine-bit fill or threshold value to a read word
  function automatic logic [31:0] zext9(input logic [8:0] v);
    return {23'h0, v};
  endfunction : zext9

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops each
  // pins idle high through their pull-ups, so the flops reset to one and
  // no false host pulse or command mode appears after rst
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic lock_n_s, hrst_n_s, cmd_s, rts_n_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
    end else begin
      sync1_q <= {rts_n_pin, cmd_sel_pin, host_reset_n_pin, baud_lock_n_pin};
      sync2_q <= sync1_q;
    end
  end

  assign lock_n_s = sync2_q[0];
  assign hrst_n_s = sync2_q[1];
  assign cmd_s = sync2_q[2];
  assign rts_n_s = sync2_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // host reset pulse qualification
  // the counter saturates, so a pin held low keeps the block in reset;
  // glitches shorter than the minimum width are ignored
  logic [3:0] hrst_cnt_q;
  logic hrst_hit;

  // R04 pulse resets device
  always_ff @(posedge clk) begin
    if (rst) begin
      hrst_cnt_q <= 4'h0;
    end else if (hrst_n_s) begin
      hrst_cnt_q <= 4'h0;
    end else if (hrst_cnt_q != 4'(RST_MIN_CYC)) begin
      hrst_cnt_q <= hrst_cnt_q + 4'h1;
    end
  end

  assign hrst_hit = !hrst_n_s && (hrst_cnt_q == 4'(RST_MIN_CYC));

  ////////////////////////////////////////////////////////////////////////////
  // power-on / reset sequencer
  rhc_state_t state_q;
  logic [15:0] por_cnt_q;
  logic forced_q;
  logic sleep_refused_q;
  logic [31:0] ctrl_q;
  logic sleep_req;

  assign sleep_req = reg_hit(wr_en, addr, REG_CTRL) && wdata[CTRL_SLEEP_REQ];

  // a host pulse restarts the whole power-on count, like a cold boot
  // R03 internal power-on reset
  always_ff @(posedge clk) begin
    if (rst || hrst_hit) begin
      state_q <= RHC_POR;
      por_cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        RHC_POR: begin
          if (por_cnt_q == 16'(POR_CYC - 1)) begin
            state_q <= RHC_RUN;
          end else begin
            por_cnt_q <= por_cnt_q + 16'h0001;
          end
        end
        RHC_RUN: begin
          // R13 refuse sleep on lock
          if (sleep_req && lock_n_s) begin
            state_q <= RHC_SLEEP;
          end
        end
        RHC_SLEEP: begin
          // R02 wake on lock
          if (!lock_n_s) begin
            state_q <= RHC_RUN;
          end
        end
        default: state_q <= RHC_POR;
      endcase
    end
  end

  // a refusal in the same cycle as a status read wins over the clear
  // R13 record refused sleep
  always_ff @(posedge clk) begin
    if (rst || hrst_hit) begin
      sleep_refused_q <= 1'b0;
    end else if (sleep_req && !lock_n_s && state_q == RHC_RUN) begin
      sleep_refused_q <= 1'b1;
    end else if (reg_hit(rd_en, addr, REG_STATUS)) begin
      sleep_refused_q <= 1'b0;
    end
  end

  // the lock level is taken once, as the power-on count ends; later
  // changes on the pin only wake the radio or refuse sleep and never leave forced mode
  // R01 sample lock at release
  // R12 exit only by reset
  always_ff @(posedge clk) begin
    if (rst || hrst_hit) begin
      forced_q <= 1'b0;
    end else if (in_por(state_q) && por_cnt_q == 16'(POR_CYC - 1)) begin
      forced_q <= !lock_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  // threshold writes that would break the hysteresis are dropped, so the
  // upper level always stays above the lower one
  logic [31:0] baud_q;
  logic [8:0] cts_on_q;
  logic [8:0] cts_off_q;
  logic [8:0] rx_fill_q;
  logic [31:0] timeout_q;
  logic [7:0] pkt_q;

  always_ff @(posedge clk) begin
    if (rst || hrst_hit) begin
      ctrl_q <= 32'h0000_0000;
      baud_q <= BAUD_RST;
      cts_on_q <= CTS_ON_RST;
      cts_off_q <= CTS_OFF_RST;
      rx_fill_q <= 9'h000;
      timeout_q <= TIMEOUT_RST;
      pkt_q <= PKT_RST;
    end else if (wr_en) begin
      case (addr)
        REG_CTRL: ctrl_q <= {27'h0, wdata[4], 1'b0, wdata[2:0]}; // sleep bit self-clears
        REG_BAUD: baud_q <= wdata;
        // R15 upper above lower
        REG_CTS_ON: if (wdata[8:0] > cts_off_q) cts_on_q <= wdata[8:0];
        REG_CTS_OFF: if (wdata[8:0] < cts_on_q) cts_off_q <= wdata[8:0];
        REG_RXFILL: rx_fill_q <= wdata[8:0];
        REG_TIMEOUT: timeout_q <= wdata;
        REG_PKTSIZE: pkt_q <= wdata[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CTS hysteresis
  // held high through power-on so the host does not send too early;
  // between the two thresholds the previous level is kept
  always_ff @(posedge clk) begin
    if (rst || hrst_hit) begin
      cts <= 1'b1;
    end else if (in_por(state_q)) begin
      cts <= 1'b1;
    end else if (rx_fill_q >= cts_on_q) begin
      // R09 raise at upper
      cts <= 1'b1;
    end else if (rx_fill_q < cts_off_q) begin
      // R10 drop below lower
      cts <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin-derived outputs
  logic running;
  assign running = (state_q == RHC_RUN);

  // sync indicator
  // R07 server always low
  // R06 client low when synced
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_n <= 1'b1;
    end else begin
      sync_n <= !(ctrl_q[CTRL_SERVER] || (ctrl_q[CTRL_SYNCED] && running));
    end
  end

  // serial output gating toward the host
  // R08 RTS gating
  // R11 forced ignores RTS
  always_ff @(posedge clk) begin
    if (rst) begin
      ser_tx_allow <= 1'b0;
    end else begin
      ser_tx_allow <= running && (forced_q || !ctrl_q[CTRL_RTS_EN] || !rts_n_s);
    end
  end

  // host byte interpretation
  // R05 command select
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_mode <= 1'b0;
    end else begin
      cmd_mode <= !cmd_s;
    end
  end

  // radio enables; command mode stops transmit but not receive
  always_ff @(posedge clk) begin
    if (rst) begin
      rf_tx_allow <= 1'b0;
      rf_rx_enable <= 1'b0;
    end else begin
      // R14 no RF transmit
      rf_tx_allow <= running && cmd_s && ctrl_q[CTRL_RF_EN];
      // R11 receiver disabled forced
      rf_rx_enable <= running && !forced_q && ctrl_q[CTRL_RF_EN];
    end
  end

  // core reset held through power-on and host pulses
  always_ff @(posedge clk) begin
    if (rst) begin
      core_reset <= 1'b1;
    end else begin
      core_reset <= in_por(state_q) || hrst_hit;
    end
  end

  // forced mode overrides the stored settings without changing them
  // R01 forced serial settings
  always_ff @(posedge clk) begin
    if (rst) begin
      baud_rate <= BAUD_RST;
      if_timeout <= TIMEOUT_RST;
      pkt_size <= PKT_RST;
    end else if (forced_q) begin
      baud_rate <= FORCED_BAUD_W;
      // R11 three ms timeout
      if_timeout <= 32'(IF_TIMEOUT_FORCED_CYC);
      pkt_size <= DEF_PKT_SIZE;
    end else begin
      baud_rate <= baud_q;
      if_timeout <= timeout_q;
      pkt_size <= pkt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after strobe
  // an unmapped offset reads as zero, and rdata falls back to zero
  // after the one cycle in which it stands
  logic [31:0] status_w;

  // status word assembled at the package field positions
  always_comb begin
    status_w = 32'h0000_0000;
    status_w[ST_FORCED] = forced_q;
    status_w[ST_SLEEP] = (state_q == RHC_SLEEP);
    status_w[ST_CMD_MODE] = cmd_mode;
    status_w[ST_CTS] = cts;
    status_w[ST_RF_TX_OK] = rf_tx_allow;
    status_w[ST_RF_RX_EN] = rf_rx_enable;
    status_w[ST_TX_OK] = ser_tx_allow;
    status_w[ST_SLEEP_REFUSED] = sleep_refused_q;
    status_w[ST_IN_POR] = in_por(state_q);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (addr)
        REG_CTRL: rdata <= ctrl_q;
        REG_STATUS: rdata <= status_w;
        REG_BAUD: rdata <= baud_q;
        REG_CTS_ON: rdata <= zext9(cts_on_q);
        REG_CTS_OFF: rdata <= zext9(cts_off_q);
        REG_RXFILL: rdata <= zext9(rx_fill_q);
        REG_TIMEOUT: rdata <= timeout_q;
        REG_PKTSIZE: rdata <= {24'h0, pkt_q};
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule : rhc_host_ctrl

// ==== pkg/rhc_pkg.sv ====
// Purpose: shared constants for the radio host-control pin block
// Assumes: 25 MHz clock, plain register port with 8-bit addresses
// Notes: all offsets, fields and counts live here, with the reset values of the baud, threshold, timeout and packet-size registers
package rhc_pkg;
  // clock and timing
  localparam int CLK_HZ = 25000000;
  localparam int IF_TIMEOUT_FORCED_MS = 3;
  localparam int IF_TIMEOUT_FORCED_CYC = (CLK_HZ / 1000) * IF_TIMEOUT_FORCED_MS;
  localparam int POR_TIME_US = 10;
  localparam int POR_CYC = (CLK_HZ / 1000000) * POR_TIME_US;
  localparam int RST_MIN_NS = 250;
  localparam int RST_MIN_CYC = (RST_MIN_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // serial settings
  localparam int FORCED_BAUD = 9600;
  localparam logic [31:0] FORCED_BAUD_W = 32'h0000_2580;
  localparam logic [7:0] DEF_PKT_SIZE = 8'h80;
  // register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_BAUD = 8'h08;
  localparam logic [7:0] REG_CTS_ON = 8'h0C;
  localparam logic [7:0] REG_CTS_OFF = 8'h10;
  localparam logic [7:0] REG_RXFILL = 8'h14;
  localparam logic [7:0] REG_TIMEOUT = 8'h18;
  localparam logic [7:0] REG_PKTSIZE = 8'h1C;
  // control fields
  localparam int CTRL_RTS_EN = 0;
  localparam int CTRL_SERVER = 1;
  localparam int CTRL_SYNCED = 2;
  localparam int CTRL_SLEEP_REQ = 3;
  localparam int CTRL_RF_EN = 4;
  // status fields
  localparam int ST_FORCED = 0;
  localparam int ST_SLEEP = 1;
  localparam int ST_CMD_MODE = 2;
  localparam int ST_CTS = 3;
  localparam int ST_RF_TX_OK = 4;
  localparam int ST_RF_RX_EN = 5;
  localparam int ST_TX_OK = 6;
  localparam int ST_SLEEP_REFUSED = 7;
  localparam int ST_IN_POR = 8;
  // reset values
  localparam logic [31:0] BAUD_RST = 32'h0001_C200;
  localparam logic [8:0] CTS_ON_RST = 9'h0C0;
  localparam logic [8:0] CTS_OFF_RST = 9'h040;
  localparam logic [31:0] TIMEOUT_RST = 32'h0000_0000;
  localparam logic [7:0] PKT_RST = 8'hFF;
endpackage : rhc_pkg

// ==== tb/rhc_ctrl_assertions.sv ====
// Purpose: port checks for the host-control block
// Assumes: only top-level ports are visible
// Notes: bound into each rhc_host_ctrl
`timescale 1ns/1ns
module rhc_ctrl_chk
  import rhc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic host_reset_n_pin,
  input wire logic cmd_sel_pin,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic cts,
  input wire logic sync_n,
  input wire logic cmd_mode,
  input wire logic rf_tx_allow,
  input wire logic core_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // host reset held long enough to count
  sequence s_pulse;
    !host_reset_n_pin [*8];
  endsequence
  // server bit written, then quiet cycles
  sequence s_server;
    wr_en && addr == REG_CTRL && wdata[CTRL_SERVER] ##1 (!wr_en && !core_reset) [*4];
  endsequence
  // buffer fill written at its top value
  sequence s_full;
    wr_en && addr == REG_RXFILL && wdata == 32'h000001FF ##1 !wr_en [*3];
  endsequence
  property p_por_hold;
    $fell(rst) |-> core_reset [*8];
  endproperty
  property p_por_cts;
    core_reset && $past(core_reset) |-> cts;
  endproperty
  property p_host_rst;
    s_pulse |-> ##[0:6] core_reset;
  endproperty
  property p_cmd_on;
    (!cmd_sel_pin && !core_reset) [*6] |-> cmd_mode;
  endproperty
  property p_cmd_off;
    (cmd_sel_pin && !core_reset) [*6] |-> !cmd_mode;
  endproperty
  property p_cmd_no_tx;
    cmd_mode [*2] |-> !rf_tx_allow;
  endproperty
  property p_server;
    s_server |-> !sync_n;
  endproperty
  property p_cts_full;
    s_full |-> cts;
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("core reset dropped early");
  a_por_cts: assert property (p_por_cts) else $error("cts low in power-on reset");
  a_host_rst: assert property (p_host_rst) else $error("host pulse ignored");
  a_cmd_on: assert property (p_cmd_on) else $error("command mode missing");
  a_cmd_off: assert property (p_cmd_off) else $error("command mode stuck");
  a_cmd_no_tx: assert property (p_cmd_no_tx) else $error("rf transmit in command mode");
  a_server: assert property (p_server) else $error("server sync output high");
  a_cts_full: assert property (p_cts_full) else $error("cts low on full buffer");
endmodule : rhc_ctrl_chk
////////////////////////////////////////
bind rhc_host_ctrl rhc_ctrl_chk u_chk (.clk(clk), .rst(rst), .host_reset_n_pin(host_reset_n_pin),
  .cmd_sel_pin(cmd_sel_pin), .addr(addr), .wdata(wdata), .wr_en(wr_en), .cts(cts), .sync_n(sync_n),
  .cmd_mode(cmd_mode), .rf_tx_allow(rf_tx_allow), .core_reset(core_reset));

// ==== tb/rhc_host_model.sv ====
// Purpose: host processor driving the control pins
// Assumes: pins idle high, as the pull-ups leave them
// Notes: tasks are called right after a rising edge
`timescale 1ns/1ns
module rhc_host_model
  import rhc_pkg::*;
(
  input wire logic clk,
  output logic baud_lock_n_pin,
  output logic host_reset_n_pin,
  output logic cmd_sel_pin,
  output logic rts_n_pin
);
  // pulled-up idle levels
  initial begin
    baud_lock_n_pin = 1'b1;
    host_reset_n_pin = 1'b1;
    cmd_sel_pin = 1'b1;
    rts_n_pin = 1'b1;
  end
  // low pulse, lock level set in the same step as its falling edge
  task automatic reset_pulse(input logic lock_n);
    baud_lock_n_pin <= lock_n;
    host_reset_n_pin <= 1'b0;
    repeat (RST_MIN_CYC + 2) @(posedge clk);
    host_reset_n_pin <= 1'b1;
  endtask : reset_pulse
  // level pins set together
  task automatic set_pins(input logic lock_n, input logic cmd, input logic rts_n);
    baud_lock_n_pin <= lock_n;
    cmd_sel_pin <= cmd;
    rts_n_pin <= rts_n;
  endtask : set_pins
endmodule : rhc_host_model

// ==== tb/rhc_host_ctrl_tb.sv ====
// Purpose: self-checking bench of the host-control block
// Assumes: reset-value thresholds while filling
// Notes: reads checked by a monitor from a queue
`timescale 1ns/1ns
module rhc_host_ctrl_tb;
  import rhc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, rd_seen = 1'b0;
  logic [7:0] addr = 8'h00, pkt_size;
  logic [31:0] wdata = 32'h0, rdata, baud_rate, if_timeout, seed = 32'hCEF9, ctl;
  logic cts, sync_n, ser_tx_allow, cmd_mode, rf_tx_allow, rf_rx_enable, core_reset, lk, hr, cs, rt;
  logic [31:0] exp_q[$];
  int fail_count = 0, n_compared = 0;
  initial begin
    forever #20 clk = ~clk;
  end
  rhc_host_model HOST (.clk(clk), .baud_lock_n_pin(lk), .host_reset_n_pin(hr), .cmd_sel_pin(cs), .rts_n_pin(rt));
  rhc_host_ctrl DUT (.clk(clk), .rst(rst), .baud_lock_n_pin(lk), .host_reset_n_pin(hr), .cmd_sel_pin(cs),
    .rts_n_pin(rt), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cts(cts),
    .sync_n(sync_n), .ser_tx_allow(ser_tx_allow), .cmd_mode(cmd_mode), .rf_tx_allow(rf_tx_allow),
    .rf_rx_enable(rf_rx_enable), .baud_rate(baud_rate), .if_timeout(if_timeout), .pkt_size(pkt_size),
    .core_reset(core_reset));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    n_compared++;
    if (seen !== e) begin
      fail_count++;
      $display("mismatch %s exp %h seen %h", nm, e, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic fill(input logic [8:0] v, input logic e);
    wr(REG_RXFILL, 32'(v));
    chk("cts", 32'(cts), 32'(e));
  endtask : fill
  task automatic wait_por();
    int n = 0;
    repeat (8) @(posedge clk);
    while (core_reset !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      fail_count++;
      report_and_stop();
    end
  endtask : wait_por
  // read data taken the cycle after each read
  always @(posedge clk) begin
    rd_seen <= rd_en;
    if (rd_seen) chk("rdata", rdata, exp_q.pop_front());
  end
  ////////////////////////////////////////
  initial begin
    ctl = (32'h1 << CTRL_RTS_EN) | (32'h1 << CTRL_RF_EN);
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wait_por();
    rd(REG_CTS_ON, 32'(CTS_ON_RST));
    rd(REG_CTS_OFF, 32'(CTS_OFF_RST));
    wr(REG_CTS_ON, 32'h00000030);
    rd(REG_CTS_ON, 32'(CTS_ON_RST));
    rd(8'h20, 32'h0);
    fill(CTS_ON_RST - 9'h1, 1'b0);
    fill(CTS_ON_RST, 1'b1);
    fill(9'h1FF, 1'b1);
    fill(CTS_OFF_RST, 1'b1);
    fill(CTS_OFF_RST - 9'h1, 1'b0);
    // sleep with the lock pin idle, wake on lock low, refuse while low
    wr(REG_CTRL, 32'h1 << CTRL_SLEEP_REQ);
    rd(REG_STATUS, 32'h1 << ST_SLEEP);
    HOST.set_pins(1'b0, 1'b1, 1'b1);
    repeat (8) @(posedge clk);
    rd(REG_STATUS, 32'h1 << ST_TX_OK);
    wr(REG_CTRL, 32'h1 << CTRL_SLEEP_REQ);
    rd(REG_STATUS, (32'h1 << ST_TX_OK) | (32'h1 << ST_SLEEP_REFUSED));
    rd(REG_STATUS, 32'h1 << ST_TX_OK);
    wr(REG_CTRL, ctl);
    chk("sync", 32'(sync_n), 32'h1);
    // random command select and ready levels
    repeat (8) begin
      seed = lfsr(seed);
      HOST.set_pins(1'b1, seed[0], seed[1]);
      repeat (8) @(posedge clk);
      chk("cmd", 32'(cmd_mode), 32'(!seed[0]));
      chk("sertx", 32'(ser_tx_allow), 32'(!seed[1]));
      chk("rftx", 32'(rf_tx_allow), 32'(seed[0]));
      chk("rfrx", 32'(rf_rx_enable), 32'h1);
    end
    wr(REG_CTRL, 32'h1 << CTRL_SYNCED);
    chk("sync", 32'(sync_n), 32'h0);
    wr(REG_CTRL, 32'h1 << CTRL_SERVER);
    chk("sync", 32'(sync_n), 32'h0);
    HOST.reset_pulse(1'b0);
    wait_por();
    HOST.set_pins(1'b1, 1'b1, 1'b1);
    wr(REG_CTRL, ctl);
    repeat (8) @(posedge clk);
    chk("baud", baud_rate, FORCED_BAUD_W);
    chk("tmo", if_timeout, 32'(IF_TIMEOUT_FORCED_CYC));
    chk("pkt", 32'(pkt_size), 32'(DEF_PKT_SIZE));
    chk("sertx", 32'(ser_tx_allow), 32'h1);
    chk("rfrx", 32'(rf_rx_enable), 32'h0);
    HOST.reset_pulse(1'b1);
    wait_por();
    chk("baud", baud_rate, BAUD_RST);
    chk("tmo", if_timeout, TIMEOUT_RST);
    chk("pkt", 32'(pkt_size), 32'(PKT_RST));
    report_and_stop();
  end
endmodule : rhc_host_ctrl_tb
